// file: shared/rsp_pkg.sv
/*
 * Constants and carrier types for the reader's serial peripheral port.
 * Assumes one core clock and one serial clock that arrives from the host.
 */
`default_nettype none

package rsp_pkg;

    // ========================================================
    // Widths, reset values and counts.
    localparam int RSP_BITS = 8;
    localparam logic [7:0] RSP_DATA_RESET = 8'h00;
    localparam logic [2:0] RSP_BIT_RESET = 3'h0;
    localparam logic [2:0] RSP_LAST_BIT = 3'h7;
    localparam logic [1:0] RSP_SYNC_RESET = 2'h0;
    localparam logic [2:0] RSP_SYNC3_RESET = 3'h0;
    // Half period of the master clock is this base shifted by the rate.
    localparam logic [4:0] RSP_HALF_BASE = 5'h02;
    localparam logic [4:0] RSP_DIV_RESET = 5'h00;

    // ========================================================
    // Serial control register, driven by the core software.
    typedef struct packed {
        logic master_en;
        logic double_speed;
        logic [1:0] rate_sel;
        logic transfer_irq_enable;
    } rsp_ctrl_type;

    // Status seen by software.
    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision;
        logic overrun;
        logic busy;
        logic sleep;
    } rsp_status_type;

    // Master clock generator states.
    typedef enum logic [0:0] {
        RSP_M_IDLE = 1'b0,
        RSP_M_SHIFT = 1'b1
    } rsp_mstate_type;

endpackage : rsp_pkg

`default_nettype wire

// file: hw/rsp_port.sv
/*
 * Serial peripheral port of the reader: slave shifter on the host clock,
 * optional master clock generator, receive buffer and status flags.
 * Assumes the host keeps the select, clock-rate and gap timing below.
 */
// Summary of operation
// - Device is a slave; it drives the serial clock only if master mode is set.
// - Transfers start on select low; select high resynchronises the slave.
// - Master to slave data uses MOSI, slave to master uses MISO.
// - In master mode a data write starts the clock for eight bits.
// - Master byte done sets the done flag; interrupt if enabled.
// - With select high MISO floats and clocks do not shift data.
// - Slave byte done sets the done flag when master mode is off; interrupt if enabled.
// - Last received byte is held in a receive buffer.
// - Transmit single buffered, receive double buffered; unread byte is lost.
// - Mode follows reset and select: reset, sleep or active.
// - Select high: ignore clock, float both data lines; in master mode MOSI stays driven.
// - After reset the port sleeps waiting for select low.
// - Clock idles low; data changes on rising, sampled on falling.
// - Double-speed master option halves the half period, doubling the clock rate; at rate 0 that is half the core clock.
// - Bytes travel most significant bit first.
`timescale 1ns/1ps
`default_nettype none

module rsp_port
    import rsp_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SCK,
    input wire logic SS_N,
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE,
    output logic SCK_O,
    output logic SCK_OE,
    input wire rsp_ctrl_type CTRL,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_WRITE,
    input wire logic RX_READ,
    output logic [7:0] RX_DATA,
    output rsp_status_type STATUS,
    output logic IRQ
);

    // ========================================================
    // Link domain: logic clocked by the host serial clock.

    // Select high holds the bit counter in reset, so no clock shifts.
    logic link_rst;
    assign link_rst = RST | SS_N;

    logic [2:0] s_cnt;
    logic [2:0] s_out_cnt;
    logic [6:0] s_shift;
    logic s_inflight;
    logic [7:0] s_rx_byte;
    logic s_done_tgl;
    logic [2:0] next_s_cnt;
    logic [6:0] next_s_shift;
    logic next_s_inflight;
    logic [7:0] next_s_rx_byte;
    logic next_s_done_tgl;

    // Falling edge samples MOSI; the eighth bit completes the byte.
    always_comb begin
        next_s_cnt = s_cnt + 3'h1;
        next_s_shift = {s_shift[5:0], MOSI_I};
        next_s_inflight = (s_cnt != RSP_LAST_BIT);
        next_s_rx_byte = s_rx_byte;
        next_s_done_tgl = s_done_tgl;
        if (s_cnt == RSP_LAST_BIT) begin
            next_s_rx_byte = {s_shift, MOSI_I};
            next_s_done_tgl = ~s_done_tgl;
        end
    end

    // Counter state, cleared whenever select is high.
    always_ff @(negedge SCK or posedge link_rst) begin
        if (link_rst) begin
            s_cnt <= RSP_BIT_RESET;
            s_shift <= RSP_DATA_RESET[6:0];
            s_inflight <= 1'b0;
        end else begin
            s_cnt <= next_s_cnt;
            s_shift <= next_s_shift;
            s_inflight <= next_s_inflight;
        end
    end

    // Completed byte survives select rising just after the last edge.
    always_ff @(negedge SCK or posedge RST) begin
        if (RST) begin
            s_rx_byte <= RSP_DATA_RESET;
            s_done_tgl <= 1'b0;
        end else begin
            s_rx_byte <= next_s_rx_byte;
            s_done_tgl <= next_s_done_tgl;
        end
    end

    // Rising edge moves MISO to the next bit.
    always_ff @(posedge SCK or posedge link_rst) begin
        if (link_rst) begin
            s_out_cnt <= RSP_BIT_RESET;
        end else begin
            s_out_cnt <= s_cnt;
        end
    end

    // ========================================================
    // Crossings into the core clock domain.

    logic [1:0] ss_sync;
    logic [1:0] infl_sync;
    logic [1:0] miso_sync;
    logic [2:0] done_sync;

    // Two flops per level; the done toggle gets a third for its edge.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ss_sync <= 2'h3;
            infl_sync <= RSP_SYNC_RESET;
            miso_sync <= RSP_SYNC_RESET;
            done_sync <= RSP_SYNC3_RESET;
        end else begin
            ss_sync <= {ss_sync[0], SS_N};
            infl_sync <= {infl_sync[0], s_inflight};
            miso_sync <= {miso_sync[0], MISO_I};
            done_sync <= {done_sync[1:0], s_done_tgl};
        end
    end

    logic slave_done;
    logic slave_busy;
    logic ss_active;
    assign slave_done = done_sync[2] ^ done_sync[1];
    assign slave_busy = infl_sync[1];
    assign ss_active = ~ss_sync[1];

    // ========================================================
    // Core domain: master clock generator and buffers.

    // Half period of the generated clock in core cycles.
    function automatic logic [4:0] half_period(input logic [1:0] rate,
                                               input logic dbl);
        logic [4:0] base;
        base = RSP_HALF_BASE << rate;
        half_period = dbl ? (base >> 1) : base;
    endfunction : half_period

    rsp_mstate_type mstate;
    rsp_mstate_type next_mstate;
    logic [4:0] div_cnt;
    logic [4:0] next_div_cnt;
    logic sck_lvl;
    logic next_sck_lvl;
    logic [2:0] m_cnt;
    logic [2:0] next_m_cnt;
    logic [7:0] m_shift;
    logic [7:0] next_m_shift;
    logic m_samp;
    logic next_m_samp;
    logic m_done;
    logic [7:0] tx_reg;
    logic [7:0] next_tx_reg;
    logic [7:0] rx_buf;
    logic [7:0] next_rx_buf;
    logic done_flag;
    logic next_done_flag;
    logic wcol;
    logic next_wcol;
    logic ovr;
    logic next_ovr;
    logic sleep;
    logic busy;
    logic wr_ok;

    assign busy = (mstate == RSP_M_SHIFT) | slave_busy;
    assign wr_ok = TX_WRITE & ~busy;

    // Master shifter: rising edge moves data, falling edge samples it.
    always_comb begin
        next_mstate = mstate;
        next_div_cnt = div_cnt;
        next_sck_lvl = sck_lvl;
        next_m_cnt = m_cnt;
        next_m_shift = m_shift;
        next_m_samp = m_samp;
        m_done = 1'b0;
        case (mstate)
            RSP_M_IDLE: begin
                if (wr_ok && CTRL.master_en) begin
                    next_mstate = RSP_M_SHIFT;
                    next_m_shift = TX_DATA;
                    next_m_cnt = RSP_BIT_RESET;
                    next_sck_lvl = 1'b0;
                    next_div_cnt = half_period(CTRL.rate_sel,
                                               CTRL.double_speed);
                end
            end
            RSP_M_SHIFT: begin
                next_div_cnt = div_cnt - 5'h01;
                if (div_cnt == 5'h01) begin
                    next_div_cnt = half_period(CTRL.rate_sel,
                                               CTRL.double_speed);
                    next_sck_lvl = ~sck_lvl;
                    if (!sck_lvl && m_cnt != RSP_BIT_RESET) begin
                        next_m_shift = {m_shift[6:0], m_samp};
                    end
                    if (sck_lvl) begin
                        next_m_samp = miso_sync[1];
                        next_m_cnt = m_cnt + 3'h1;
                        if (m_cnt == RSP_LAST_BIT) begin
                            next_mstate = RSP_M_IDLE;
                            m_done = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_mstate = RSP_M_IDLE;
            end
        endcase
    end

    // Buffers and flags; a new event wins over a read in the same cycle.
    always_comb begin
        next_tx_reg = wr_ok ? TX_DATA : tx_reg;
        next_wcol = wcol;
        if (TX_WRITE) begin
            next_wcol = busy;
        end
        next_rx_buf = rx_buf;
        next_done_flag = done_flag & ~RX_READ;
        next_ovr = ovr & ~RX_READ;
        if (m_done) begin
            next_rx_buf = {m_shift[6:0], miso_sync[1]};
        end else if (slave_done && !CTRL.master_en) begin
            next_rx_buf = s_rx_byte;
        end
        if (m_done || (slave_done && !CTRL.master_en)) begin
            next_done_flag = 1'b1;
            next_ovr = ovr | (done_flag & ~RX_READ);
        end
    end

    // Registers of the core domain.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            mstate <= RSP_M_IDLE;
            div_cnt <= RSP_DIV_RESET;
            sck_lvl <= 1'b0;
            m_cnt <= RSP_BIT_RESET;
            m_shift <= RSP_DATA_RESET;
            m_samp <= 1'b0;
            tx_reg <= RSP_DATA_RESET;
            rx_buf <= RSP_DATA_RESET;
            done_flag <= 1'b0;
            wcol <= 1'b0;
            ovr <= 1'b0;
            sleep <= 1'b1;
        end else begin
            mstate <= next_mstate;
            div_cnt <= next_div_cnt;
            sck_lvl <= next_sck_lvl;
            m_cnt <= next_m_cnt;
            m_shift <= next_m_shift;
            m_samp <= next_m_samp;
            tx_reg <= next_tx_reg;
            rx_buf <= next_rx_buf;
            done_flag <= next_done_flag;
            wcol <= next_wcol;
            ovr <= next_ovr;
            sleep <= ~ss_active;
        end
    end

    // ========================================================
    // Pins and status.

    // Slave output: bit chosen by the rising-edge count, MSB first.
    assign MISO_O = tx_reg[3'h7 - s_out_cnt];
    assign MISO_OE = ~SS_N & ~CTRL.master_en;
    assign MOSI_O = m_shift[7];
    assign MOSI_OE = CTRL.master_en;
    assign SCK_O = sck_lvl;
    assign SCK_OE = CTRL.master_en;
    assign RX_DATA = rx_buf;
    assign IRQ = done_flag & CTRL.transfer_irq_enable;
    assign STATUS = '{transfer_done_flag: done_flag,
                      write_collision: wcol,
                      overrun: ovr,
                      busy: busy,
                      sleep: sleep};

endmodule : rsp_port

`default_nettype wire

// file: verification/rsp_port_chk.sv
/* Port checker of the serial port.
   Assumes it is bound to rsp_port and that RST is active high. */
`timescale 1ns/1ps
`default_nettype none
module rsp_port_chk
    import rsp_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SS_N,
    input wire logic MISO_OE,
    input wire logic MOSI_OE,
    input wire logic SCK_O,
    input wire logic SCK_OE,
    input wire rsp_ctrl_type CTRL,
    input wire logic TX_WRITE,
    input wire logic RX_READ,
    input wire rsp_status_type STATUS,
    input wire logic IRQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // ==========================================================
    // Assertions on the port outputs.
    miso_float_a: assert property (SS_N || CTRL.master_en |-> !MISO_OE)
        else $error("MISO driven while deselected.");
    miso_drive_a: assert property (!SS_N && !CTRL.master_en |-> MISO_OE)
        else $error("MISO not driven while selected.");
    clk_own_a: assert property (SCK_OE == CTRL.master_en && MOSI_OE == SCK_OE)
        else $error("Clock or MOSI driven in slave mode.");
    irq_level_a: assert property (IRQ == (STATUS.transfer_done_flag && CTRL.transfer_irq_enable))
        else $error("IRQ mismatch.");
    sleep_mode_a: assert property ($stable(SS_N) [*6] |-> STATUS.sleep == SS_N)
        else $error("Sleep status does not follow select.");
    flag_hold_a: assert property (STATUS.transfer_done_flag && !RX_READ |=> STATUS.transfer_done_flag)
        else $error("Done flag lost before read.");
    wr_refuse_a: assert property (TX_WRITE && STATUS.busy |=> STATUS.write_collision)
        else $error("Write during shift not refused.");
    wr_take_a: assert property (TX_WRITE && !STATUS.busy |=> !STATUS.write_collision)
        else $error("Idle write refused.");
    read_clear_a: assert property (RX_READ |=> !STATUS.overrun)
        else $error("Overrun kept after read.");
    ovr_cause_a: assert property ($rose(STATUS.overrun) |-> $past(STATUS.transfer_done_flag))
        else $error("Overrun without unread byte.");
    clk_idle_a: assert property (CTRL.master_en && !STATUS.busy |-> !SCK_O)
        else $error("Master clock not idle low.");
    // Main scenarios reached.
    cover property ($rose(STATUS.transfer_done_flag));
    cover property ($rose(STATUS.overrun));
    cover property ($rose(STATUS.write_collision));
endmodule : rsp_port_chk
bind rsp_port rsp_port_chk i_chk (.MCLK, .RST, .SS_N, .MISO_OE, .MOSI_OE,
    .SCK_O, .SCK_OE, .CTRL, .TX_WRITE, .RX_READ, .STATUS, .IRQ);
`default_nettype wire

// file: verification/rsp_host_model.sv
/* Host model: serial master driving select, clock and MOSI.
   Assumes its tasks are called by the testbench one at a time. */
`timescale 1ns/1ps
`default_nettype none
module rsp_host_model (
    output logic SCK,
    output logic SS_N,
    output logic MOSI,
    input wire logic MISO
);
    logic lclk;
    // ==========================================================
    // Link clock of 15 ns; SCK toggles every two ticks, 60 ns period.
    initial begin
        lclk = 1'b0;
        SCK = 1'b0;
        SS_N = 1'b1;
        MOSI = 1'b0;
        forever #7.5 lclk = ~lclk;
    end
    task automatic lw(input int n);
        repeat (n) @(posedge lclk);
    endtask : lw
    // Select low, then 3 us before the first clock.
    task automatic open_f();
        SS_N <= 1'b0;
        lw(200);
    endtask : open_f
    // Select high; released MOSI shows the inverse of its last value.
    task automatic close_f();
        SS_N <= 1'b1;
        MOSI <= ~MOSI;
        lw(4);
    endtask : close_f
    // Shifts n bits MSB first at a quarter of the core rate at most.
    task automatic xfer(input logic [7:0] tx, input int n,
        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            SCK <= 1'b1;
            MOSI <= tx[i];
            lw(2);
            SCK <= 1'b0;
            rx[i] = MISO;
            lw(2);
        end
        lw(1550);
    endtask : xfer
    // Clock pulses while deselected, which the port must ignore.
    task automatic stray(input int n);
        repeat (n) begin
            SCK <= 1'b1;
            lw(2);
            SCK <= 1'b0;
            lw(2);
        end
    endtask : stray
endmodule : rsp_host_model
`default_nettype wire

// file: verification/tb_rsp_port.sv
/* Testbench of the serial port: slave bytes, faults, master rates.
   Assumes the host model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module tb_rsp_port;
    import rsp_pkg::*;
    logic MCLK, RST, TX_WRITE, RX_READ, MOSI_O, MOSI_OE, MISO_O, MISO_OE;
    logic SCK_O, SCK_OE, IRQ;
    logic [7:0] TX_DATA, RX_DATA, a, b, s;
    wire logic SCK, SS_N, MOSI_I, MISO_I, hmiso;
    rsp_ctrl_type CTRL;
    rsp_status_type STATUS;
    int err_count, comparisons, k;
    // ==========================================================
    // Design, host and loopback of the master data lines.
    rsp_port i_dut (.MCLK, .RST, .SCK, .SS_N, .MOSI_I, .MOSI_O, .MOSI_OE,
        .MISO_I, .MISO_O, .MISO_OE, .SCK_O, .SCK_OE, .CTRL, .TX_DATA,
        .TX_WRITE, .RX_READ, .RX_DATA, .STATUS, .IRQ);
    rsp_host_model i_host (.SCK, .SS_N, .MOSI(MOSI_I), .MISO(hmiso));
    assign hmiso = MISO_OE ? MISO_O : 1'bz;
    assign MISO_I = MOSI_O;
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] v);
        comparisons++;
        if (v !== e) begin
            err_count++;
            $display("Error %s: expected %h seen %h", w, e, v);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge MCLK);
            #1;
        end
    endtask : cyc
    task automatic wr(input logic [7:0] d);
        TX_DATA = d;
        TX_WRITE = 1'b1;
        cyc(1);
        TX_WRITE = 1'b0;
    endtask : wr
    // Waits for the done flag, then reads and clears it.
    task automatic rd();
        int n;
        n = 0;
        while (STATUS.transfer_done_flag !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        chk("irq", {7'h0, CTRL.transfer_irq_enable}, {7'h0, IRQ});
        if (n == 5000) begin
            err_count++;
            final_report();
        end
        RX_READ = 1'b1;
        cyc(1);
        RX_READ = 1'b0;
    endtask : rd
    // One full slave byte: load while asleep, shift, check both ways.
    task automatic sbyte(input logic [7:0] t, input logic [7:0] r);
        wr(t);
        i_host.open_f();
        chk("awake", 8'h00, {7'h0, STATUS.sleep});
        i_host.xfer(r, 8, s);
        i_host.close_f();
        chk("miso byte", t, s);
        chk("rx data", r, RX_DATA);
    endtask : sbyte
    // ==========================================================
    // Main sequence.
    initial begin
        RST = 1'b1;
        CTRL = '0;
        TX_DATA = 8'h00;
        TX_WRITE = 1'b0;
        RX_READ = 1'b0;
        void'($urandom(53));
        cyc(2);
        RST = 1'b0;
        cyc(3);
        chk("sleep", 8'h01, {7'h0, STATUS.sleep});
        chk("rx reset", 8'h00, RX_DATA);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            CTRL.transfer_irq_enable = i[0];
            a = (i == 0) ? 8'hFF : 8'($urandom);
            b = (i == 0) ? 8'h00 : 8'($urandom);
            sbyte(a, b);
            rd();
            chk("flag clear", 8'h00, {7'h0, STATUS.transfer_done_flag});
        end
        $display("test slave bytes done");
        i_host.stray(8);
        cyc(8);
        chk("stray clocks", 8'h00, {7'h0, STATUS.transfer_done_flag});
        i_host.open_f();
        i_host.xfer(8'hA5, 3, s);
        wr(8'h3C);
        chk("collision", 8'h01, {7'h0, STATUS.write_collision});
        i_host.close_f();
        sbyte(8'hC3, 8'h5A);
        sbyte(8'h81, 8'h7E);
        chk("overrun", 8'h01, {7'h0, STATUS.overrun});
        rd();
        $display("test faults done");
        // As master the bench plays software; no far select is needed.
        for (int r = 0; r < 4; r++) begin
            for (int d = 0; d < 2; d++) begin
                CTRL = '{1'b1, d[0], r[1:0], 1'b1};
                b = 8'($urandom);
                wr(b);
                k = 0;
                while (SCK_O !== 1'b1 && k < 100) begin
                    cyc(1);
                    k++;
                end
                if (k == 100) begin
                    err_count++;
                    final_report();
                end
                k = 0;
                while (SCK_O === 1'b1 && k < 100) begin
                    cyc(1);
                    k++;
                end
                if (k == 100) begin
                    err_count++;
                    final_report();
                end
                chk("half period", 8'((2 << r) >> d), k[7:0]);
                rd();
                // Synchronised MISO needs half periods of four or more.
                if (((2 << r) >> d) >= 4) begin
                    chk("master rx", b, RX_DATA);
                end
            end
        end
        $display("test master done");
        final_report();
    end
endmodule : tb_rsp_port
`default_nettype wire
